// >>> rtl/qpd_rom_defs.vh
`ifndef QPD_ROM_DEFS_VH
`define QPD_ROM_DEFS_VH

// extended query table base and descriptor query locations
`define QPD_EXT_BASE        12'h10A
`define QPD_T1_ENDUR_LOC    12'h13A
`define QPD_T1_CELL_LOC     12'h13C
`define QPD_T1_ACCESS_LOC   12'h13D
`define QPD_T1_PROG_LOC     12'h13E
`define QPD_T2_GEOM_LOC     12'h144
`define QPD_T2_ENDUR_LOC    12'h148
`define QPD_T2_CELL_LOC     12'h14A
`define QPD_T2_ACCESS_LOC   12'h14B
`define QPD_T1_PROG_LEN     12'h006
`define QPD_T2_GEOM_LEN     12'h004
`define QPD_LOC_FIRST       12'h13A
`define QPD_LOC_LAST        12'h14B

// field positions
`define QPD_CELL_BPC_MSB    3
`define QPD_CELL_ECC_BIT    4
`define QPD_ACC_PAGE_BIT    0
`define QPD_ACC_SRD_BIT     1
`define QPD_ACC_SWR_BIT     2

// own control register: bit 0 selects the bottom parameter configuration
`define QPD_CFG_OFFSET      12'h000
`define QPD_CFG_BOTTOM_BIT  0
`define QPD_CFG_RESET       1'h1

// value reported at query locations with no descriptor
`define QPD_UNMAPPED_BYTE   8'hFF

`endif

// >>> rtl/qpd_rom.v
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "qpd_rom_defs.vh"

module qpd_rom #(
   parameter [15:0] T1_ENDURANCE    = 16'h0064,
   parameter [3:0]  T1_BITS_PER_CELL = 4'h2,
   parameter        T1_ECC_USED     = 1'b0,
   parameter        T1_PAGE_READ    = 1'b1,
   parameter        T1_SYNC_READ    = 1'b1,
   parameter        T1_SYNC_WRITE   = 1'b0,
   parameter [7:0]  T1_PROG_EXP     = 8'h00,
   parameter        T1_PROG_LEGACY  = 1'b1,
   parameter [7:0]  T1_CTL_VALID    = 8'h00,
   parameter [7:0]  T1_CTL_INVALID  = 8'h00,
   parameter        T1_CTL_LEGACY   = 1'b1,
   parameter [15:0] T2_BLOCKS_M1    = 16'h01FE,
   parameter [15:0] T2_SIZE_256     = 16'h0200,
   parameter [15:0] T2_ENDURANCE    = 16'h0064,
   parameter [3:0]  T2_BITS_PER_CELL = 4'h2,
   parameter        T2_ECC_USED     = 1'b0,
   parameter        T2_PAGE_READ    = 1'b1,
   parameter        T2_SYNC_READ    = 1'b1,
   parameter        T2_SYNC_WRITE   = 1'b0
) (
   input  wire        i_ref_clk,
   input  wire        i_rstn,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [13:0] i_paddr,
   input  wire [31:0] i_pwdata,
   input  wire [3:0]  i_pstrb,
   output reg  [31:0] o_prdata,
   output reg         o_pready,
   output reg         o_pslverr
);

   localparam [1:0] ST_IDLE   = 2'h0;
   localparam [1:0] ST_ACCESS = 2'h1;

   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg         bottom_reg;
   reg  [7:0]  query_byte;
   reg         cfg_hit;
   reg         loc_hit;
   wire [11:0] word_idx;
   wire        setup;

   assign word_idx = i_paddr[13:2];
   assign setup    = i_psel & ~i_penable;

   function [7:0] cell_info;
      input [3:0] bpc;
      input       ecc;
      begin
         cell_info = 8'h00;
         cell_info[`QPD_CELL_BPC_MSB:0] = bpc;
         cell_info[`QPD_CELL_ECC_BIT]   = ecc;
      end
   endfunction

   function [7:0] access_caps;
      input page;
      input srd;
      input swr;
      begin
         access_caps = 8'h00;
         access_caps[`QPD_ACC_PAGE_BIT] = page;
         access_caps[`QPD_ACC_SRD_BIT]  = srd;
         access_caps[`QPD_ACC_SWR_BIT]  = swr;
      end
   endfunction

   // fixed descriptors; reserved bits are zero
   wire [47:0] t1_prog = {T1_CTL_LEGACY, 7'h00, T1_CTL_INVALID,
                          8'h00, T1_CTL_VALID,
                          T1_PROG_LEGACY, 7'h00, T1_PROG_EXP};
   wire [31:0] t2_geom = {T2_SIZE_256, T2_BLOCKS_M1};

   // query location decode; index is the word offset on the bus
   always @* begin
      query_byte = `QPD_UNMAPPED_BYTE;
      loc_hit    = 1'b1;
      case (word_idx)
         `QPD_T1_ENDUR_LOC:        query_byte = T1_ENDURANCE[7:0];
         `QPD_T1_ENDUR_LOC + 12'h1: query_byte = T1_ENDURANCE[15:8];
         `QPD_T1_CELL_LOC:
            query_byte = cell_info(T1_BITS_PER_CELL, T1_ECC_USED);
         `QPD_T1_ACCESS_LOC:
            query_byte = access_caps(T1_PAGE_READ, T1_SYNC_READ, T1_SYNC_WRITE);
         `QPD_T1_PROG_LOC:         query_byte = t1_prog[7:0];
         `QPD_T1_PROG_LOC + 12'h1: query_byte = t1_prog[15:8];
         `QPD_T1_PROG_LOC + 12'h2: query_byte = t1_prog[23:16];
         `QPD_T1_PROG_LOC + 12'h3: query_byte = t1_prog[31:24];
         `QPD_T1_PROG_LOC + 12'h4: query_byte = t1_prog[39:32];
         `QPD_T1_PROG_LOC + 12'h5: query_byte = t1_prog[47:40];
         `QPD_T2_GEOM_LOC:
            query_byte = bottom_reg ? t2_geom[7:0] : `QPD_UNMAPPED_BYTE;
         `QPD_T2_GEOM_LOC + 12'h1:
            query_byte = bottom_reg ? t2_geom[15:8] : `QPD_UNMAPPED_BYTE;
         `QPD_T2_GEOM_LOC + 12'h2:
            query_byte = bottom_reg ? t2_geom[23:16] : `QPD_UNMAPPED_BYTE;
         `QPD_T2_GEOM_LOC + 12'h3:
            query_byte = bottom_reg ? t2_geom[31:24] : `QPD_UNMAPPED_BYTE;
         `QPD_T2_ENDUR_LOC:         query_byte = T2_ENDURANCE[7:0];
         `QPD_T2_ENDUR_LOC + 12'h1: query_byte = T2_ENDURANCE[15:8];
         `QPD_T2_CELL_LOC:
            query_byte = cell_info(T2_BITS_PER_CELL, T2_ECC_USED);
         `QPD_T2_ACCESS_LOC:
            query_byte = access_caps(T2_PAGE_READ, T2_SYNC_READ, T2_SYNC_WRITE);
         default:
            loc_hit = 1'b0;
      endcase
      cfg_hit = (word_idx == `QPD_CFG_OFFSET);
   end

   always @* begin
      case (state_reg)
         ST_IDLE:   state_next = setup ? ST_ACCESS : ST_IDLE;
         ST_ACCESS: state_next = ST_IDLE;
         default:   state_next = ST_IDLE;
      endcase
   end

   // no wait state: answer in the cycle after the setup phase
   always @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg  <= ST_IDLE;
         bottom_reg <= `QPD_CFG_RESET;
         o_prdata   <= 32'h00000000;
         o_pready   <= 1'b0;
         o_pslverr  <= 1'b0;
      end else begin
         state_reg <= state_next;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         // read data stands only in the ready cycle, zero otherwise
         o_prdata  <= 32'h00000000;
         if (state_reg == ST_IDLE && setup) begin
            o_pready <= 1'b1;
            o_prdata <= 32'h00000000;
            if (i_pwrite) begin
               // query locations are read only; writes there are refused
               if (cfg_hit) begin
                  if (i_pstrb[0]) begin
                     bottom_reg <= i_pwdata[`QPD_CFG_BOTTOM_BIT];
                  end
               end else begin
                  o_pslverr <= 1'b1;
               end
            end else if (cfg_hit) begin
               o_prdata <= {31'h00000000, bottom_reg};
            end else if (loc_hit) begin
               o_prdata <= {24'h000000, query_byte};
            end else begin
               o_pslverr <= 1'b1;
            end
         end
      end
   end

   // base 10A is where the extended table starts; the query locations above include it, the control offset 000 does not
   wire unused_ok = &{1'b0, i_paddr[1:0], i_pstrb[3:1], i_pwdata[31:1]};

endmodule // qpd_rom
`default_nettype wire

// >>> verification/qpd_rom_sva.sv
`timescale 1ns/100ps
`default_nettype none
module qpd_rom_sva (
   input wire logic        i_ref_clk,
   input wire logic        i_rstn,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [13:0] i_paddr,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   sequence s_set;
      i_psel && !i_penable;
   endsequence
   sequence s_rd(l);
      s_set ##0 !i_pwrite && i_paddr[13:2] == l;
   endsequence
   AST_ANSWER: assert property (s_set |=> o_pready) else $error("no answer");
   AST_PULSE: assert property (o_pready |=> !o_pready) else $error("ready held");
   AST_QUIET: assert property (!o_pready |-> o_prdata == 0 && !o_pslverr) else $error("idle");
   AST_BYTE: assert property (o_pready |-> o_prdata[31:8] == 0) else $error("upper");
   AST_WRERR: assert property (s_set ##0 i_pwrite && i_paddr[13:2] != 0 |=> o_pslverr)
      else $error("write taken");
   AST_MAP: assert property (s_set ##0 !i_pwrite && i_paddr[13:2] inside {[12'h13A:12'h14B]}
      |=> !o_pslverr) else $error("mapped error");
   AST_CELL: assert property (s_rd(12'h13C) |=> o_prdata[7:5] == 0) else $error("cell");
   AST_ACC: assert property (s_rd(12'h14B) |=> o_prdata[7:3] == 0) else $error("access");
endmodule // qpd_rom_sva
bind qpd_rom qpd_rom_sva qpd_rom_sva_inst (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));
`default_nettype wire

// >>> verification/qpd_host.sv
`timescale 1ns/100ps
`default_nettype none
module qpd_host (
   input  wire logic        i_ref_clk,
   input  wire logic        i_pready,
   output var  logic        o_psel,
   output var  logic        o_penable,
   output var  logic        o_pwrite,
   output var  logic [13:0] o_paddr,
   output var  logic [31:0] o_pwdata,
   output var  logic        o_hang
);
   initial {o_psel, o_penable, o_pwrite, o_hang, o_paddr, o_pwdata} = '0;
   task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} <= {2'b10, w, a, d};
      @(posedge i_ref_clk);
      o_penable <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (i_pready !== 1'b1 && n < 20);
      o_hang <= o_hang | (n >= 20);
      // released lines show the inverse so stale values cannot pass
      {o_psel, o_penable, o_paddr, o_pwdata} <= {2'b00, ~a, ~d};
   endtask
endmodule // qpd_host
`default_nettype wire

// >>> verification/query_partition_descriptor_rom_bench.sv
`timescale 1ns/100ps
`default_nettype none
module query_partition_descriptor_rom_bench;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, hang;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [32:0] expq[$];
   int          error_cnt = 0, cmp_count = 0, seed = 95370, i;
   localparam logic [143:0] TBL = 144'h64000203008000000080FE01000264000203;
   always #5 clk = ~clk;
   qpd_rom qpd_rom_inst (.i_ref_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
   qpd_host qpd_host_inst (.i_ref_clk(clk), .i_pready(pready), .o_psel(psel),
      .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .o_hang(hang));
   task automatic chk(input logic [32:0] e, input logic [32:0] g);
      cmp_count++;
      if (e !== g) begin
         error_cnt++;
         $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic acc(input logic w, input logic [11:0] l, input logic [31:0] d, logic [32:0] e);
      expq.push_back(e);
      qpd_host_inst.xfer(w, {l, 2'b00}, d);
   endtask
   task automatic scan(input logic bot);
      for (int k = 0; k < 18; k++) begin
         acc(1'b0, 12'(12'h13A + k), $random(seed),
            {25'h0, (!bot && k > 9 && k < 14) ? 8'hFF : TBL[8 * (17 - k) +: 8]});
      end
   endtask
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1) begin
         chk(expq.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
      end
   end
   task give_verdict;
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      acc(1'b0, 12'h000, 32'h0, 33'h1);
      scan(1'b1);
      for (i = 0; i < 6; i++) begin
         acc(1'b1, 12'(12'h13A + ($random(seed) & 15)), $random(seed), {1'b1, 32'h0});
      end
      acc(1'b1, 12'h000, 32'hFFFFFFFE, 33'h0);
      scan(1'b0);
      acc(1'b1, 12'h000, 32'h1, 33'h0);
      scan(1'b1);
      acc(1'b0, 12'h139, 32'h0, {1'b1, 32'h0});
      acc(1'b0, 12'h14C, 32'h0, {1'b1, 32'h0});
      repeat (3) @(posedge clk);
      error_cnt += hang;
      give_verdict;
   end
endmodule // query_partition_descriptor_rom_bench
`default_nettype wire
